// >>> verilog/brk_mon_pkg.sv
// Constants shared by the break and monitor entry logic
package brk_mon_pkg;
   // ****************
   // Register byte addresses
   // ****************
   localparam logic [4:0] OFS_STATUS_CONTROL = 5'h00;
   localparam logic [4:0] OFS_ADDRESS_HIGH   = 5'h04;
   localparam logic [4:0] OFS_ADDRESS_LOW    = 5'h08;
   localparam logic [4:0] OFS_WAIT_STATUS    = 5'h0c;
   localparam logic [4:0] OFS_FLAG_CONTROL   = 5'h10;
   localparam logic [4:0] OFS_AUXILIARY      = 5'h14;
   localparam logic [4:0] OFS_MONITOR_STATUS = 5'h18;
   // ****************
   // Field positions and reset values
   // ****************
   localparam int        BIT_MATCH_ENABLE  = 7;
   localparam int        BIT_ACTIVE_FLAG   = 6;
   localparam int        BIT_WAIT_FLAG     = 1;
   localparam int        BIT_CLEAR_ENABLE  = 7;
   localparam int        BIT_WDOG_DISABLE  = 0;
   localparam logic [7:0] RESET_BYTE       = 8'h00;
   // ****************
   // Vectors and monitor entry
   // ****************
   localparam logic [7:0]  USER_VECTOR_PAGE = 8'hff;
   localparam logic [7:0]  MON_VECTOR_PAGE  = 8'hfe;
   localparam logic [7:0]  SWI_VECTOR_LOW   = 8'hfc;
   localparam logic [15:0] RESET_VEC_HIGH   = 16'hfffe;
   localparam logic [15:0] RESET_VEC_LOW    = 16'hffff;
   localparam logic [7:0]  ERASED_BYTE      = 8'hff;
   localparam logic [4:0]  COMM_SAMPLE_CYC  = 5'h18;
   localparam logic [3:0]  BREAK_BITS       = 4'ha;
   localparam logic [10:0] BIT_CYCLES       = 11'h400;
   typedef enum logic {TX_IDLE = 1'b0, TX_SEND = 1'b1} tx_state_type;
endpackage

// >>> verilog/break_and_monitor_entry.sv
// Break address unit and monitor mode entry control
`timescale 1ns/100ps
// Contract
// - Enabled breakpoint raises a break on a full 16-bit program address match.
// - Active flag sets on every address match and reads back as one.
// - Software writing one to the active flag requests a break interrupt.
// - Active flag clears only by a written zero or reset; software clears it.
// - Two address bytes hold the breakpoint, both zero after reset.
// - Wait flag sets when a break ends wait mode; zero write or reset clears.
// - A break in stop mode wakes the processor and sets the wait flag.
// - During a break, other flags clear only if the clear enable is one.
// - Break watchdog disable holds the watchdog off during a break.
// - The comparator keeps running in wait mode.
// - Monitor entry by test voltage with straps, or erased reset vector.
// - Comm select low with line high gives serial; high gives parallel entry.
// - Test voltage bypasses the internal clock generator for the external clock.
// - Normal monitor with test voltage turns the oscillator pin into reset.
// - Watchdog off in normal monitor with test voltage, else configuration bit.
// - Erased reset vector fetch without test voltage forces internal reset.
// - Forced monitor disables watchdog and survives all but power-on reset.
// - Monitor mode relocates the reset and SWI interrupt vectors to the fe page.
// - After eight security bytes the device sends ten zero bits.
// - Link uses NRZ mark/space frames at equal rates both ways.
// - The serial line is open-drain, never actively driven high.
// - Break starts after the current instruction, or at once on its last cycle.
// - Timer counters stop during a break.
module break_and_monitor_entry
   import brk_mon_pkg::*;
(
   // Clock and resets
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        por_arst_n,
   // Avalon-MM slave
   input  wire logic [4:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [3:0]  byteenable,
   input  wire logic [31:0] writedata,
   output logic      [31:0] readdata,
   output logic             waitrequest,
   // Processor side
   input  wire logic [15:0] cpu_addr,
   input  wire logic        cpu_fetch,
   input  wire logic        instr_last_cycle,
   input  wire logic        instr_done,
   input  wire logic        in_wait,
   input  wire logic        in_stop,
   input  wire logic [15:0] vector_addr_in,
   input  wire logic        vector_fetch,
   input  wire logic [7:0]  vector_data,
   input  wire logic        security_done,
   output logic             break_request,
   output logic             wake_request,
   output logic [15:0]      vector_addr_out,
   output logic             internal_reset_req,
   // System controls
   input  wire logic        watchdog_disable_cfg,
   output logic             status_clear_allow,
   output logic             watchdog_enable,
   output logic             timer_stop,
   output logic             clock_bypass_external,
   output logic             osc_pin_as_reset,
   output logic             monitor_mode,
   output logic             serial_comm_mode,
   output logic             parallel_comm_mode,
   // Pins
   input  wire logic        test_voltage_pin,
   input  wire logic        mode_select0_pin,
   input  wire logic        mode_select1_pin,
   input  wire logic        comm_select_pin,
   input  wire logic        serial_line_in,
   output logic             serial_line_out,
   output logic             serial_line_oe
);
   logic [15:0] break_addr;
   logic        match_enable_reg;
   logic        active_flag_reg;
   logic        wait_flag_reg;
   logic        clear_enable_reg;
   logic        wdog_disable_reg;
   logic        pending_reg;
   logic        ack_reg;
   logic        wr_take;
   logic        addr_match;
   logic        brk_fire;
   logic [7:0]  addr_high_reg;
   logic [7:0]  addr_low_reg;
   logic [7:0]  rd_byte;
   logic [2:0]  sync1_reg;
   logic [2:0]  sync2_reg;
   logic [2:0]  sync3_reg;
   logic [2:0]  sync4_reg;
   logic        testv;
   logic        normal_mon_reg;
   logic        forced_mon_reg;
   logic        straps_done_reg;
   logic [4:0]  comm_cnt_reg;
   logic        serial_mode_reg;
   logic        parallel_mode_reg;
   logic        erased_high_reg;
   tx_state_type tx_state_reg;
   logic [10:0] bit_cnt_reg;
   logic [3:0]  bits_left_reg;

   // ****************
   // Pin synchronisers
   // ****************
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sync1_reg <= 3'h0;
         sync2_reg <= 3'h0;
         sync3_reg <= 3'h0;
         sync4_reg <= 3'h0;
      end
      else
      begin
         sync1_reg <= {test_voltage_pin, mode_select1_pin, mode_select0_pin};
         sync2_reg <= sync1_reg;
         sync3_reg <= {1'b0, serial_line_in, comm_select_pin};
         sync4_reg <= sync3_reg;
      end
   end
   assign testv = sync2_reg[2];

   // ****************
   // Avalon slave
   // ****************
   // One wait cycle; read data is registered on the first edge
   assign waitrequest = (read | write) & ~ack_reg;
   assign wr_take     = write & ack_reg & byteenable[0];

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         ack_reg <= 1'b0;
      else
         ack_reg <= (read | write) & ~ack_reg;
   end

   always_comb
   begin
      case (address)
         OFS_STATUS_CONTROL: rd_byte = {match_enable_reg, active_flag_reg, 6'h00};
         OFS_ADDRESS_HIGH:   rd_byte = addr_high_reg;
         OFS_ADDRESS_LOW:    rd_byte = addr_low_reg;
         OFS_WAIT_STATUS:    rd_byte = {6'h00, wait_flag_reg, 1'b0};
         OFS_FLAG_CONTROL:   rd_byte = {clear_enable_reg, 7'h00};
         OFS_AUXILIARY:      rd_byte = {7'h00, wdog_disable_reg};
         OFS_MONITOR_STATUS: rd_byte = {3'h0, parallel_mode_reg, serial_mode_reg,
                                        forced_mon_reg, normal_mon_reg, testv};
         default:            rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         readdata <= 32'h00000000;
      else if (read & ~ack_reg)
         readdata <= {24'h000000, rd_byte};
   end

   // ****************
   // Break registers
   // ****************
   // address bytes cleared by reset
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         addr_high_reg    <= RESET_BYTE;
         addr_low_reg     <= RESET_BYTE;
         clear_enable_reg <= 1'b0;
         wdog_disable_reg <= 1'b0;
         match_enable_reg <= 1'b0;
      end
      else if (wr_take)
      begin
         if (address == OFS_ADDRESS_HIGH)
            addr_high_reg <= writedata[7:0];
         if (address == OFS_ADDRESS_LOW)
            addr_low_reg <= writedata[7:0];
         if (address == OFS_FLAG_CONTROL)
            clear_enable_reg <= writedata[BIT_CLEAR_ENABLE];
         if (address == OFS_AUXILIARY)
            wdog_disable_reg <= writedata[BIT_WDOG_DISABLE];
         if (address == OFS_STATUS_CONTROL)
            match_enable_reg <= writedata[BIT_MATCH_ENABLE];
      end
   end
   assign break_addr = {addr_high_reg, addr_low_reg};

   // full 16-bit compare; not gated by wait mode
   assign addr_match = match_enable_reg & cpu_fetch & (cpu_addr == break_addr);

   // hardware set wins over a zero write
   // cleared only by a zero write or reset
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         active_flag_reg <= 1'b0;
      else if (addr_match)
         active_flag_reg <= 1'b1;
      else if (wr_take && address == OFS_STATUS_CONTROL)
         active_flag_reg <= writedata[BIT_ACTIVE_FLAG];
   end

   // hold a match until the instruction in flight ends
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         pending_reg <= 1'b0;
      else if (brk_fire)
         pending_reg <= 1'b0;
      else if (addr_match)
         pending_reg <= 1'b1;
   end

   // match on the last cycle fires at once
   // a written one also fires a break
   assign brk_fire = ((pending_reg | addr_match) & (instr_done | instr_last_cycle))
                   | (wr_take & (address == OFS_STATUS_CONTROL) & writedata[BIT_ACTIVE_FLAG]);

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         break_request <= 1'b0;
         wake_request  <= 1'b0;
      end
      else
      begin
         break_request <= brk_fire;
         // a break also wakes from stop
         wake_request  <= brk_fire & (in_wait | in_stop);
      end
   end

   // set on a break leaving wait; also from stop
   // a written one never sets it
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         wait_flag_reg <= 1'b0;
      else if (brk_fire & (in_wait | in_stop))
         wait_flag_reg <= 1'b1;
      else if (wr_take && address == OFS_WAIT_STATUS && !writedata[BIT_WAIT_FLAG])
         wait_flag_reg <= 1'b0;
   end

   // other flags clearable in break only when enabled
   assign status_clear_allow = ~active_flag_reg | clear_enable_reg;
   assign timer_stop = active_flag_reg;

   // ****************
   // Monitor entry
   // ****************
   // straps caught once, after the synchronisers have filled
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         straps_done_reg <= 1'b0;
         normal_mon_reg  <= 1'b0;
      end
      else if (!straps_done_reg && comm_cnt_reg == 5'h02)
      begin
         straps_done_reg <= 1'b1;
         normal_mon_reg  <= sync2_reg[2] & ~sync2_reg[1] & sync2_reg[0];
      end
   end

   // watch both reset vector bytes outside test voltage
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         erased_high_reg <= 1'b0;
      else if (vector_fetch && vector_addr_in == RESET_VEC_HIGH)
         erased_high_reg <= (vector_data == ERASED_BYTE);
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         internal_reset_req <= 1'b0;
      else
         internal_reset_req <= vector_fetch & ~testv & ~forced_mon_reg & erased_high_reg
                             & (vector_addr_in == RESET_VEC_LOW) & (vector_data == ERASED_BYTE);
   end

   // only power-on reset leaves forced monitor mode
   always_ff @(posedge clk or negedge por_arst_n)
   begin
      if (!por_arst_n)
         forced_mon_reg <= 1'b0;
      else if (internal_reset_req)
         forced_mon_reg <= 1'b1;
   end

   // the host keeps comm select low for these 24 cycles
   // link style chosen once the window closes
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         comm_cnt_reg      <= 5'h00;
         serial_mode_reg   <= 1'b0;
         parallel_mode_reg <= 1'b0;
      end
      else if (comm_cnt_reg != COMM_SAMPLE_CYC)
         comm_cnt_reg <= comm_cnt_reg + 5'h01;
      else if (!serial_mode_reg && !parallel_mode_reg && monitor_mode)
      begin
         serial_mode_reg   <= ~sync4_reg[0] & sync4_reg[1];
         parallel_mode_reg <= sync4_reg[0];
      end
   end
   assign serial_comm_mode   = serial_mode_reg;
   assign parallel_comm_mode = parallel_mode_reg;
   assign monitor_mode       = normal_mon_reg | forced_mon_reg;

   // external clock only while test voltage is present
   assign clock_bypass_external = testv;
   // oscillator pin reverts when test voltage drops
   assign osc_pin_as_reset = normal_mon_reg & testv;
   // off in normal monitor with test voltage, forced, break with disable bit, or config bit
   assign watchdog_enable = ~(normal_mon_reg & testv) & ~forced_mon_reg
                          & ~(wdog_disable_reg & active_flag_reg) & ~watchdog_disable_cfg;

   // fe page vectors in monitor mode
   always_comb
   begin
      vector_addr_out = vector_addr_in;
      if (monitor_mode && vector_addr_in[15:8] == USER_VECTOR_PAGE
          && vector_addr_in[7:0] >= SWI_VECTOR_LOW)
         vector_addr_out = {MON_VECTOR_PAGE, vector_addr_in[7:0]};
   end

   // ****************
   // Ready break on the serial line
   // ****************
   // ten zero bits after security bytes
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         tx_state_reg  <= TX_IDLE;
         bit_cnt_reg   <= 11'h000;
         bits_left_reg <= 4'h0;
      end
      else
      begin
         case (tx_state_reg)
            TX_IDLE:
            begin
               if (security_done && serial_mode_reg)
               begin
                  tx_state_reg  <= TX_SEND;
                  bit_cnt_reg   <= BIT_CYCLES - 11'h001;
                  bits_left_reg <= BREAK_BITS;
               end
            end
            TX_SEND:
            begin
               if (bit_cnt_reg != 11'h000)
                  bit_cnt_reg <= bit_cnt_reg - 11'h001;
               else if (bits_left_reg == 4'h1)
                  tx_state_reg <= TX_IDLE;
               else
               begin
                  bit_cnt_reg   <= BIT_CYCLES - 11'h001;
                  bits_left_reg <= bits_left_reg - 4'h1;
               end
            end
            default:
               tx_state_reg <= TX_IDLE;
         endcase
      end
   end

   // NRZ space is the line pulled low for a whole bit
   // open drain, low only, pull-up gives the mark
   assign serial_line_out = 1'b0;
   assign serial_line_oe  = (tx_state_reg == TX_SEND);

   // ****************
   // Assertions
   // ****************
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);

   a_match_sets_active: assert property (addr_match |=> active_flag_reg)
      else $error("match did not set active flag");
   a_no_match_disabled: assert property (!match_enable_reg && !pending_reg && !wr_take |=> !break_request)
      else $error("break raised while disabled");
   a_active_sticky: assert property (active_flag_reg && !wr_take |=> active_flag_reg)
      else $error("active flag dropped without write");
   a_soft_break: assert property (wr_take && address == OFS_STATUS_CONTROL
      && writedata[BIT_ACTIVE_FLAG] |=> break_request)
      else $error("software break not requested");
   a_pending_fires: assert property (pending_reg && instr_done |=> break_request)
      else $error("pending break lost");
   a_wait_set: assert property (brk_fire && in_stop |=> wait_flag_reg && wake_request)
      else $error("stop exit not flagged");
   a_wait_only_hw: assert property (!wait_flag_reg && !(brk_fire && (in_wait || in_stop)) |=> !wait_flag_reg)
      else $error("wait flag set without break");
   a_clear_gate: assert property (active_flag_reg && !clear_enable_reg |-> !status_clear_allow)
      else $error("flag clear allowed in break");
   a_wdog_forced: assert property (forced_mon_reg |-> !watchdog_enable)
      else $error("watchdog on in forced monitor");
   a_line_low_only: assert property (serial_line_oe |-> !serial_line_out)
      else $error("line driven high");
   a_break_length: assert property ($rose(serial_line_oe) |-> serial_line_oe [*8])
      else $error("break too short");
   a_vec_remap: assert property (monitor_mode && vector_addr_in == RESET_VEC_HIGH
      |-> vector_addr_out[15:8] == MON_VECTOR_PAGE)
      else $error("vector not relocated");

   c_match_break: cover property (addr_match ##[1:20] break_request);
   c_soft_break: cover property (wr_take && address == OFS_STATUS_CONTROL ##1 break_request);
   c_ready_break: cover property ($rose(serial_line_oe));
   c_wait_exit: cover property (brk_fire && in_wait ##1 wait_flag_reg);
endmodule

// >>> testbench/host_model.sv
// Host computer model on the open-drain serial line
`timescale 1ns/100ps
module host_model
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        arst_n,
   // Device side of the line
   input  wire logic        serial_line_out,
   input  wire logic        serial_line_oe,
   // Pins seen by the device
   output logic             comm_select_pin,
   output logic             serial_line,
   // Measurements
   output logic [15:0]      last_low_len,
   output logic             drove_high
);
   logic [15:0] low_len_reg;
   assign comm_select_pin = 1'b0;
   assign serial_line = ~(serial_line_oe & ~serial_line_out);
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         low_len_reg  <= 16'h0000;
         last_low_len <= 16'h0000;
         drove_high   <= 1'b0;
      end
      else
      begin
         low_len_reg <= serial_line ? 16'h0000 : low_len_reg + 16'h0001;
         if (serial_line && low_len_reg != 16'h0000)
            last_low_len <= low_len_reg;
         if (serial_line_oe && serial_line_out)
            drove_high <= 1'b1;
      end
   end
endmodule

// >>> testbench/tb.sv
// Self-checking bench for break and monitor entry
`timescale 1ns/100ps
module tb;
   import brk_mon_pkg::*;
   // ****************
   // Signals
   // ****************
   logic        clk, arst_n, por_arst_n, read, write, waitrequest;
   logic [4:0]  address;
   logic [3:0]  byteenable;
   logic [31:0] writedata, readdata;
   logic [15:0] cpu_addr, vector_addr_in, vector_addr_out, last_low_len;
   logic        cpu_fetch, instr_last_cycle, instr_done, in_wait, in_stop;
   logic        vector_fetch, security_done, break_request, wake_request;
   logic [7:0]  vector_data;
   logic        internal_reset_req, watchdog_disable_cfg, status_clear_allow;
   logic        watchdog_enable, timer_stop, clock_bypass_external, osc_pin_as_reset;
   logic        monitor_mode, serial_comm_mode, parallel_comm_mode, drove_high;
   logic        test_voltage_pin, mode_select0_pin, mode_select1_pin, comm_select_pin;
   logic        serial_line, serial_line_out, serial_line_oe, got_a, got_b;
   int          n_errors, n_checks, cycle_count, n;

   break_and_monitor_entry u_dut (.clk, .arst_n, .por_arst_n, .address, .read, .write, .byteenable,
      .writedata, .readdata, .waitrequest, .cpu_addr, .cpu_fetch, .instr_last_cycle, .instr_done,
      .in_wait, .in_stop, .vector_addr_in, .vector_fetch, .vector_data, .security_done, .break_request,
      .wake_request, .vector_addr_out, .internal_reset_req, .watchdog_disable_cfg, .status_clear_allow,
      .watchdog_enable, .timer_stop, .clock_bypass_external, .osc_pin_as_reset, .monitor_mode,
      .serial_comm_mode, .parallel_comm_mode, .test_voltage_pin, .mode_select0_pin, .mode_select1_pin,
      .comm_select_pin, .serial_line_in(serial_line), .serial_line_out, .serial_line_oe);
   host_model u_host (.clk, .arst_n, .serial_line_out, .serial_line_oe, .comm_select_pin,
      .serial_line, .last_low_len, .drove_high);

   always #50 clk = ~clk;
   // ****************
   // Checking and bus tasks
   // ****************
   task automatic give_verdict();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic report(input logic ok, input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (!ok)
      begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check_bit(input logic got, input logic exp);
      report(got === exp, 16'(got), 16'(exp));
   endtask
   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      report(got === exp, 16'(got), 16'(exp));
   endtask
   task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
      report(got === exp, got, exp);
   endtask
   task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
      @(posedge clk);
      address   <= a;
      writedata <= {24'h000000, d};
      read      <= ~wr;
      write     <= wr;
      do
         @(posedge clk);
      while (waitrequest !== 1'b0);
      q = readdata[7:0];
      read  <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic reg_wr(input logic [4:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic reg_chk(input logic [4:0] a, input logic [7:0] exp);
      logic [7:0] q;
      bus(1'b0, a, 8'h00, q);
      check_byte(q, exp);
   endtask
   task automatic do_reset(input logic por);
      @(posedge clk);
      arst_n     <= 1'b0;
      por_arst_n <= ~por;
      repeat (2) @(posedge clk);
      arst_n     <= 1'b1;
      por_arst_n <= 1'b1;
      repeat (30) @(posedge clk);
   endtask
   // Drives one cycle, then looks at the cycle after the sampling edge
   task automatic cpu_cycle(input logic [15:0] a, input logic f, input logic l, input logic d);
      @(posedge clk);
      cpu_addr         <= a;
      cpu_fetch        <= f;
      instr_last_cycle <= l;
      instr_done       <= d;
      @(posedge clk);
      cpu_fetch        <= 1'b0;
      instr_last_cycle <= 1'b0;
      instr_done       <= 1'b0;
      @(negedge clk);
   endtask
   // Pulse outputs may land a few cycles after a register write
   task automatic poll_pulses();
      got_a = 1'b0;
      got_b = 1'b0;
      repeat (4)
      begin
         @(negedge clk);
         got_a = got_a | (break_request === 1'b1) | (internal_reset_req === 1'b1);
         got_b = got_b | (wake_request === 1'b1);
      end
   endtask
   // ****************
   // Scenarios
   // ****************
   task automatic test_reset_values();
      reg_chk(OFS_STATUS_CONTROL, RESET_BYTE); // flags clear
      reg_chk(OFS_ADDRESS_HIGH, RESET_BYTE); // high byte clear
      reg_chk(OFS_ADDRESS_LOW, RESET_BYTE); // low byte clear
      reg_chk(OFS_WAIT_STATUS, RESET_BYTE); // wait clear
      reg_chk(OFS_AUXILIARY, RESET_BYTE); // aux clear
      reg_wr(5'h1c, 8'h5a);
      reg_chk(5'h1c, 8'h00);
      byteenable <= 4'he;
      reg_wr(OFS_ADDRESS_HIGH, 8'h77);
      byteenable <= 4'h1;
      reg_chk(OFS_ADDRESS_HIGH, 8'h00); // lane ignored
      vector_addr_in <= RESET_VEC_HIGH;
      watchdog_disable_cfg <= 1'b1;
      @(negedge clk);
      check_word(vector_addr_out, RESET_VEC_HIGH); // user vector
      check_bit(watchdog_enable, 1'b0); // config bit
      watchdog_disable_cfg <= 1'b0;
   endtask
   task automatic test_match_break();
      reg_wr(OFS_ADDRESS_HIGH, 8'h12);
      reg_wr(OFS_ADDRESS_LOW, 8'h34);
      reg_chk(OFS_ADDRESS_LOW, 8'h34); // low byte held
      cpu_cycle(16'h1234, 1'b1, 1'b1, 1'b0);
      check_bit(break_request, 1'b0); // disabled
      reg_wr(OFS_STATUS_CONTROL, 8'h80);
      cpu_cycle(16'h0234, 1'b1, 1'b1, 1'b0);
      check_bit(break_request, 1'b0); // all bits compared
      in_wait <= 1'b1;
      cpu_cycle(16'h1234, 1'b1, 1'b0, 1'b0);
      check_bit(break_request, 1'b0); // waits for end
      cpu_cycle(16'h1234, 1'b0, 1'b0, 1'b1);
      check_bit(break_request, 1'b1); // break at end
      check_bit(wake_request, 1'b1); // wakes from wait
      in_wait <= 1'b0;
      reg_chk(OFS_STATUS_CONTROL, 8'hc0); // active reads one
      reg_chk(OFS_WAIT_STATUS, 8'h02); // wait set
      check_bit(timer_stop, 1'b1); // timers held
      check_bit(status_clear_allow, 1'b0); // clears blocked
      reg_wr(OFS_FLAG_CONTROL, 8'h80);
      @(negedge clk);
      check_bit(status_clear_allow, 1'b1); // clears allowed
      check_bit(watchdog_enable, 1'b1); // bit low
      reg_wr(OFS_AUXILIARY, 8'h01);
      @(negedge clk);
      check_bit(watchdog_enable, 1'b0); // held off
      reg_wr(OFS_WAIT_STATUS, 8'h00);
      reg_chk(OFS_WAIT_STATUS, 8'h00); // zero clears
      reg_chk(OFS_STATUS_CONTROL, 8'hc0); // still active
      reg_wr(OFS_STATUS_CONTROL, 8'h00);
      reg_chk(OFS_STATUS_CONTROL, 8'h00); // zero clears
      @(negedge clk);
      check_bit(timer_stop, 1'b0); // timers run
      check_bit(watchdog_enable, 1'b1); // only in break
   endtask
   task automatic test_soft_break();
      in_stop <= 1'b1;
      reg_wr(OFS_STATUS_CONTROL, 8'h40);
      poll_pulses();
      check_bit(got_a, 1'b1); // software break
      check_bit(got_b, 1'b1); // wakes from stop
      in_stop <= 1'b0;
      reg_chk(OFS_WAIT_STATUS, 8'h02); // wait set
      reg_wr(OFS_WAIT_STATUS, 8'h00);
      reg_wr(OFS_WAIT_STATUS, 8'h02);
      reg_chk(OFS_WAIT_STATUS, 8'h00); // write one ignored
      reg_wr(OFS_STATUS_CONTROL, 8'h00);
   endtask
   task automatic test_normal_monitor();
      test_voltage_pin <= 1'b1;
      mode_select0_pin <= 1'b1;
      do_reset(1'b0);
      check_bit(monitor_mode, 1'b1); // test voltage entry
      check_bit(clock_bypass_external, 1'b1); // external clock
      check_bit(osc_pin_as_reset, 1'b1); // reset pin
      check_bit(watchdog_enable, 1'b0); // watchdog off
      check_bit(serial_comm_mode, 1'b1); // serial chosen
      check_bit(parallel_comm_mode, 1'b0); // no parallel
      reg_chk(OFS_MONITOR_STATUS, 8'h0b); // normal status
      vector_addr_in <= 16'hfffc;
      @(negedge clk);
      check_word(vector_addr_out, {MON_VECTOR_PAGE, SWI_VECTOR_LOW}); // interrupt vector
      @(posedge clk);
      security_done <= 1'b1;
      @(posedge clk);
      security_done <= 1'b0;
      n = 0;
      do
      begin
         @(negedge clk);
         n++;
      end
      while (serial_line_oe !== 1'b0 && n < 12000);
      repeat (2) @(posedge clk);
      check_word(last_low_len, 16'(BREAK_BITS) * 16'(BIT_CYCLES)); // ten zero bits
      check_bit(drove_high, 1'b0); // never driven high
      test_voltage_pin <= 1'b0;
      repeat (6) @(negedge clk);
      check_bit(clock_bypass_external, 1'b0); // bypass removed
      check_bit(osc_pin_as_reset, 1'b0); // user function
      check_bit(watchdog_enable, 1'b1); // follows config
   endtask
   task automatic test_forced_monitor();
      mode_select0_pin <= 1'b0;
      do_reset(1'b1);
      vector_data <= ERASED_BYTE;
      for (int i = 0; i < 2; i++)
      begin
         @(posedge clk);
         vector_addr_in <= i == 0 ? RESET_VEC_HIGH : RESET_VEC_LOW;
         vector_fetch   <= 1'b1;
         @(posedge clk);
         vector_fetch   <= 1'b0;
      end
      poll_pulses();
      check_bit(got_a, 1'b1); // erased vector reset
      for (int i = 0; i < 2; i++)
      begin
         do_reset(1'b0);
         check_bit(monitor_mode, 1'b1); // forced entry kept
         check_bit(watchdog_enable, 1'b0); // watchdog off
      end
      reg_chk(OFS_MONITOR_STATUS, 8'h0c); // forced status
      vector_addr_in <= RESET_VEC_HIGH;
      @(negedge clk);
      check_word(vector_addr_out, 16'hfefe); // reset vector
      do_reset(1'b1);
      check_bit(monitor_mode, 1'b0); // cleared by power-on
   endtask
   // ****************
   // Main sequence and timeout
   // ****************
   always @(posedge clk)
   begin
      cycle_count++;
      if (cycle_count == 40000)
      begin
         n_errors++;
         give_verdict();
      end
   end
   initial
   begin
      {clk, arst_n, por_arst_n, read, write, cpu_fetch, instr_last_cycle, instr_done} = '0;
      {in_wait, in_stop, vector_fetch, security_done, watchdog_disable_cfg} = '0;
      {test_voltage_pin, mode_select0_pin, mode_select1_pin} = '0;
      {address, writedata, cpu_addr, vector_addr_in, vector_data} = '0;
      byteenable = 4'h1;
      {n_errors, n_checks, cycle_count} = '0;
      do_reset(1'b1);
      test_reset_values();
      test_match_break();
      test_soft_break();
      test_normal_monitor();
      test_forced_monitor();
      give_verdict();
   end
endmodule
